// ### design/beacon_superframe_csma_cfg.v
// AXI4-Lite register bank for beacon order, superframe order and carrier-sense mode control
//
// Overview of operation
// - Upper nibble holds beacon interval exponent
// - All-ones interval: no beacon, active exponent ignored
// - Lower nibble holds active-period exponent
// - All-ones active exponent: no active portion
// - Bypass bit skips collision avoidance when unslotted and the slot switch is set
// - Bit 6 enables battery saving mode
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "beacon_superframe_csma_cfg_regs.vh"

module beacon_superframe_csma_cfg (
  // Clock and reset
  input wire clk,
  input wire rst,
  // AXI4-Lite write address channel
  input wire [`CFG_ADDR_W-1:0] awaddr,
  input wire awvalid,
  output reg awready,
  // AXI4-Lite write data channel
  input wire [`CFG_DATA_W-1:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // AXI4-Lite write response channel
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // AXI4-Lite read address channel
  input wire [`CFG_ADDR_W-1:0] araddr,
  input wire arvalid,
  output reg arready,
  // AXI4-Lite read data channel
  output reg [`CFG_DATA_W-1:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Transmit control qualifier, same clock
  input wire guaranteedSlotSwitch,
  // Configuration toward the MAC
  output reg [`EXP_W-1:0] beaconIntervalExponent,
  output reg [`EXP_W-1:0] activePeriodExponent,
  output reg beaconEnable,
  output reg activePeriodEnable,
  output reg orderConsistent,
  output reg carrierSenseBypass,
  output reg batterySavingMode,
  output reg skipCollisionAvoid
);

  // Shared address decode for both read and write paths
  function [1:0] addrSelect;
    input [`CFG_ADDR_W-1:0] addr;
    begin
      case (addr)
        `ADDR_BEACON_SUPERFRAME_ORDER: addrSelect = `SEL_ORDER;
        `ADDR_CARRIER_SENSE_MODE_CTRL: addrSelect = `SEL_MODE;
        `ADDR_CFG_STATUS: addrSelect = `SEL_STATUS;
        default: addrSelect = `SEL_NONE;
      endcase
    end
  endfunction

  reg [`CFG_REG_W-1:0] order_q;
  reg [`CFG_REG_W-1:0] order_d;
  reg [`CFG_REG_W-1:0] mode_q;
  reg [`CFG_REG_W-1:0] mode_d;

  reg awFull_q;
  reg awFull_d;
  reg [`CFG_ADDR_W-1:0] awAddr_q;
  reg [`CFG_ADDR_W-1:0] awAddr_d;
  reg wFull_q;
  reg wFull_d;
  reg [`CFG_REG_W-1:0] wData_q;
  reg [`CFG_REG_W-1:0] wData_d;
  reg wStrb_q;
  reg wStrb_d;

  reg awready_d;
  reg wready_d;
  reg bvalid_d;
  reg [1:0] bresp_d;
  reg arready_d;
  reg rvalid_d;
  reg [`CFG_DATA_W-1:0] rdata_d;
  reg [1:0] rresp_d;

  reg doWrite;
  reg [1:0] wSel;
  reg [1:0] rSel;

  wire beaconEnableNow;
  wire activePeriodEnableNow;
  wire orderConsistentNow;
  wire skipCollisionAvoidNow;
  wire [`STAT_W-1:0] statusNow;

  superframe_status decodeUnit (
    .orderValue(order_q),
    .modeValue(mode_q),
    .guaranteedSlotSwitch(guaranteedSlotSwitch),
    .beaconEnable(beaconEnableNow),
    .activePeriodEnable(activePeriodEnableNow),
    .orderConsistent(orderConsistentNow),
    .skipCollisionAvoid(skipCollisionAvoidNow)
  );

  // Status reflects the registered outputs, so it matches what the MAC sees
  assign statusNow = {skipCollisionAvoid, orderConsistent, activePeriodEnable, beaconEnable};

  // Write path: address and data are latched independently, in either order
  always @* begin
    awFull_d = awFull_q;
    awAddr_d = awAddr_q;
    wFull_d = wFull_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bvalid_d = bvalid;
    bresp_d = bresp;
    order_d = order_q;
    mode_d = mode_q;
    doWrite = 1'b0;
    wSel = addrSelect(awAddr_q);
    if (awvalid && awready) begin
      awFull_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && wready) begin
      wFull_d = 1'b1;
      wData_d = wdata[`CFG_REG_W-1:0];
      wStrb_d = wstrb[0];
    end
    if (bvalid && bready) begin
      bvalid_d = 1'b0;
    end
    if (awFull_q && wFull_q && !bvalid) begin
      doWrite = 1'b1;
    end
    if (doWrite) begin
      awFull_d = 1'b0;
      wFull_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `RESP_OKAY;
      // Only the low byte lane carries register bits
      if (wSel == `SEL_ORDER && wStrb_q) begin
        order_d = wData_q;
      end else if (wSel == `SEL_MODE && wStrb_q) begin
        mode_d = wData_q;
      end else if (wSel == `SEL_NONE) begin
        bresp_d = `RESP_SLVERR;
      end
    end
    // Ready drops while a beat is held, which is the back-pressure to the master
    awready_d = !awFull_d && !bvalid_d;
    wready_d = !wFull_d && !bvalid_d;
  end

  // Read path: one read in flight, answered the cycle after the address is taken
  always @* begin
    rvalid_d = rvalid;
    rdata_d = rdata;
    rresp_d = rresp;
    rSel = addrSelect(araddr);
    if (rvalid && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d = `RESP_OKAY;
      rdata_d = {`CFG_DATA_W{1'b0}};
      case (rSel)
        `SEL_ORDER: rdata_d[`CFG_REG_W-1:0] = order_q;
        `SEL_MODE: rdata_d[`CFG_REG_W-1:0] = mode_q;
        `SEL_STATUS: rdata_d[`STAT_W-1:0] = statusNow;
        default: rresp_d = `RESP_SLVERR;
      endcase
    end
    arready_d = !rvalid_d;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      order_q <= `RST_BEACON_SUPERFRAME_ORDER;
      mode_q <= `RST_CARRIER_SENSE_MODE_CTRL;
      awFull_q <= 1'b0;
      awAddr_q <= {`CFG_ADDR_W{1'b0}};
      wFull_q <= 1'b0;
      wData_q <= {`CFG_REG_W{1'b0}};
      wStrb_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= {`CFG_DATA_W{1'b0}};
      rresp <= `RESP_OKAY;
    end else begin
      order_q <= order_d;
      mode_q <= mode_d;
      awFull_q <= awFull_d;
      awAddr_q <= awAddr_d;
      wFull_q <= wFull_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      awready <= awready_d;
      wready <= wready_d;
      bvalid <= bvalid_d;
      bresp <= bresp_d;
      arready <= arready_d;
      rvalid <= rvalid_d;
      rdata <= rdata_d;
      rresp <= rresp_d;
    end
  end

  // Behaviour outputs are registered; they follow a register write by one cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      beaconIntervalExponent <= `EXP_RST;
      activePeriodExponent <= `EXP_RST;
      beaconEnable <= 1'b0;
      activePeriodEnable <= 1'b0;
      orderConsistent <= 1'b0;
      carrierSenseBypass <= 1'b0;
      batterySavingMode <= 1'b0;
      skipCollisionAvoid <= 1'b0;
    end else begin
      beaconIntervalExponent <= order_q[`BIE_MSB:`BIE_LSB];
      activePeriodExponent <= order_q[`APE_MSB:`APE_LSB];
      beaconEnable <= beaconEnableNow;
      activePeriodEnable <= activePeriodEnableNow;
      orderConsistent <= orderConsistentNow;
      carrierSenseBypass <= mode_q[`MODE_BYPASS_BIT];
      batterySavingMode <= mode_q[`MODE_BATTERY_BIT];
      skipCollisionAvoid <= skipCollisionAvoidNow;
    end
  end

endmodule
`default_nettype wire

// ### design/superframe_status.v
// Decode of the order and mode control values into superframe and access behaviour
`timescale 1ns/1ps
`default_nettype none
`include "beacon_superframe_csma_cfg_regs.vh"

module superframe_status (
  // Stored configuration
  input wire [`CFG_REG_W-1:0] orderValue,
  input wire [`CFG_REG_W-1:0] modeValue,
  // Transmit request qualifier from the transmit control register
  input wire guaranteedSlotSwitch,
  // Decoded behaviour
  output wire beaconEnable,
  output wire activePeriodEnable,
  output wire orderConsistent,
  output wire skipCollisionAvoid
);

  wire [`EXP_W-1:0] bie;
  wire [`EXP_W-1:0] ape;

  assign bie = orderValue[`BIE_MSB:`BIE_LSB];
  assign ape = orderValue[`APE_MSB:`APE_LSB];

  // All ones means no beacon at all
  assign beaconEnable = (bie != `EXP_OFF);
  // Active exponent is ignored while beacons are off
  assign activePeriodEnable = beaconEnable && (ape != `EXP_OFF);
  // Software is expected to keep active <= interval <= 14; flag it when it does not
  assign orderConsistent = (bie <= `EXP_MAX) && (ape <= bie);
  // Bypass applies only to unslotted sends with the slot switch set
  assign skipCollisionAvoid = modeValue[`MODE_BYPASS_BIT] && !modeValue[`MODE_SLOTTED_BIT]
                              && guaranteedSlotSwitch;

endmodule
`default_nettype wire

// ### dv/cfg_checker_sva.sv
// Port-level checks for the beacon/superframe register bank
`timescale 1ns/1ps
`default_nettype none
module cfg_checker (
  // Clock, reset and bus handshakes
  input wire logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready,
  input wire logic arvalid, arready, rvalid, rready,
  input wire logic [1:0] bresp,
  input wire logic [31:0] rdata,
  // Slot switch input and configuration outputs
  input wire logic guaranteedSlotSwitch, beaconEnable, activePeriodEnable, orderConsistent,
  input wire logic carrierSenseBypass, batterySavingMode, skipCollisionAvoid,
  input wire logic [3:0] beaconIntervalExponent, activePeriodExponent
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_beacon_off: assert property (beaconEnable == (beaconIntervalExponent != 4'hf))
    else $error("beacon enable does not match interval exponent");
  a_active_off: assert property (activePeriodEnable == (beaconEnable && activePeriodExponent != 4'hf))
    else $error("active period enable wrong");
  a_order_flag: assert property (orderConsistent == (beaconIntervalExponent <= 4'he &&
    activePeriodExponent <= beaconIntervalExponent)) else $error("order flag wrong");
  a_skip_cause: assert property (skipCollisionAvoid |-> carrierSenseBypass && $past(guaranteedSlotSwitch))
    else $error("collision avoidance skipped without cause");
  a_cfg_change: assert property (($changed(beaconIntervalExponent) || $changed(activePeriodExponent)
    || $changed(batterySavingMode)) |-> $past(bvalid) || $past(bvalid, 2)) else $error("config moved without write");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule
bind beacon_superframe_csma_cfg cfg_checker i_chk (.clk, .rst, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .bresp, .rdata, .guaranteedSlotSwitch,
  .beaconEnable, .activePeriodEnable, .orderConsistent, .carrierSenseBypass, .batterySavingMode,
  .skipCollisionAvoid, .beaconIntervalExponent, .activePeriodExponent);
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the beacon/superframe register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, gss;
  logic awready, wready, bvalid, arready, rvalid, beaconEnable, activePeriodEnable, orderConsistent;
  logic carrierSenseBypass, batterySavingMode, skipCollisionAvoid;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb, beaconIntervalExponent, activePeriodExponent;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  int nMismatch = 0;
  int nTests = 0;
  beacon_superframe_csma_cfg i_dut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .guaranteedSlotSwitch(gss), .beaconIntervalExponent, .activePeriodExponent, .beaconEnable,
    .activePeriodEnable, .orderConsistent, .carrierSenseBypass, .batterySavingMode, .skipCollisionAvoid);
  task chk(string n, logic [31:0] e, logic [31:0] g);
    nTests++;
    if (g !== e) begin
      nMismatch++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] d, logic [1:0] e);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, e}, {30'h0, bresp});
  endtask
  task rd(logic [7:0] a, logic [7:0] d, logic [1:0] e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rresp", {30'h0, e}, {30'h0, rresp});
    chk("rdata", {24'h0, d}, rdata);
  endtask
  // Outputs lag the stored value by a cycle after the response
  task settle;
    repeat (3) @(posedge clk);
  endtask
  task t_reset;
    rd(8'h40, 8'hff, 2'h0);
    rd(8'h44, 8'h1c, 2'h0);
    chk("beaconEnable", 0, beaconEnable);
    chk("activeEnable", 0, activePeriodEnable);
    $display("test reset done");
  endtask
  task t_order;
    for (int k = 0; k < 15; k++) begin
      wr(8'h40, {k[3:0], k[3:0]}, 2'h0);
      rd(8'h40, {k[3:0], k[3:0]}, 2'h0);
      settle;
      chk("intervalExp", k, beaconIntervalExponent);
      chk("activeExp", k, activePeriodExponent);
      chk("activeEnable", 1, activePeriodEnable);
      chk("orderOk", 1, orderConsistent);
    end
    wr(8'h40, 8'hf3, 2'h0);
    settle;
    chk("beaconOff", 0, beaconEnable);
    chk("activeIgnored", 0, activePeriodEnable);
    chk("orderHigh", 0, orderConsistent);
    wr(8'h40, 8'h35, 2'h0);
    settle;
    chk("orderInverted", 0, orderConsistent);
    chk("activeOn", 1, activePeriodEnable);
    wr(8'h40, 8'h5f, 2'h0);
    settle;
    chk("beaconOn", 1, beaconEnable);
    chk("noActive", 0, activePeriodEnable);
    $display("test order done");
  endtask
  task step(logic [7:0] m, logic s, logic sk);
    wr(8'h44, m, 2'h0);
    gss <= s;
    settle;
    chk("skipCa", sk, skipCollisionAvoid);
    chk("bypass", m[7], carrierSenseBypass);
    chk("battery", m[6], batterySavingMode);
  endtask
  task t_mode;
    step(8'h80, 1'b1, 1'b1);
    step(8'h80, 1'b0, 1'b0);
    step(8'ha0, 1'b1, 1'b0);
    step(8'h40, 1'b1, 1'b0);
    rd(8'h44, 8'h40, 2'h0);
    $display("test mode done");
  endtask
  task t_err;
    rd(8'h20, 8'h00, 2'h2);
    wr(8'h20, 8'h00, 2'h2);
    wr(8'h18, 8'hff, 2'h0);
    rd(8'h40, 8'h5f, 2'h0);
    rd(8'h18, 8'h01, 2'h0);
    $display("test errors done");
  endtask
  task finalReport;
    $display("checks %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2000000;
    nMismatch++;
    finalReport;
  end
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, gss} = 7'h40;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset;
    t_order;
    t_mode;
    t_err;
    finalReport;
  end
endmodule
`default_nettype wire

// ### include/beacon_superframe_csma_cfg_regs.vh
// Register map, field layout and reset values of the beacon/superframe configuration bank
`ifndef BEACON_SUPERFRAME_CSMA_CFG_REGS_VH
`define BEACON_SUPERFRAME_CSMA_CFG_REGS_VH

`define CFG_ADDR_W 8
`define CFG_DATA_W 32
`define CFG_REG_W 8

// One aligned word per register: byte address is four times the register index
`define IDX_BEACON_SUPERFRAME_ORDER 6'h10
`define IDX_CARRIER_SENSE_MODE_CTRL 6'h11
`define IDX_CFG_STATUS 6'h06
`define ADDR_BEACON_SUPERFRAME_ORDER {`IDX_BEACON_SUPERFRAME_ORDER, 2'h0}
`define ADDR_CARRIER_SENSE_MODE_CTRL {`IDX_CARRIER_SENSE_MODE_CTRL, 2'h0}
`define ADDR_CFG_STATUS {`IDX_CFG_STATUS, 2'h0}

`define RST_BEACON_SUPERFRAME_ORDER 8'hff
`define RST_CARRIER_SENSE_MODE_CTRL 8'h1c

`define SEL_NONE 2'h0
`define SEL_ORDER 2'h1
`define SEL_MODE 2'h2
`define SEL_STATUS 2'h3

`define BIE_MSB 7
`define BIE_LSB 4
`define APE_MSB 3
`define APE_LSB 0
`define EXP_W 4
`define EXP_OFF 4'hf
`define EXP_MAX 4'he
`define EXP_RST 4'hf

`define MODE_BYPASS_BIT 7
`define MODE_BATTERY_BIT 6
`define MODE_SLOTTED_BIT 5

`define STAT_BEACON_BIT 0
`define STAT_ACTIVE_BIT 1
`define STAT_CONSISTENT_BIT 2
`define STAT_SKIPCA_BIT 3
`define STAT_W 4

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif
